// *** inc/nlc_pkg.sv ***
// Constants and types for the nlc unit.
// Assumes one clock and synchronous-read RAM and ROM.
package nlc_pkg;

  // ---
  // Widths
  // ---
  localparam int RAM_AW = 7;
  localparam int IDX_W = 12;
  localparam int ROM_DW = 8;
  localparam int SYNC_W = 10;

  // ---
  // Reset values
  // ---
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [IDX_W-1:0] IDX_RST = 12'h000;
  localparam logic [7:0] EN_RST = 8'h00;

  // ---
  // Masks; reserved bits zero
  // ---
  localparam logic [7:0] IRQ_EN_MASK = 8'h2F;
  localparam logic [7:0] HALT_WAKE_MASK = 8'h2E;
  localparam logic [7:0] STOP_WAKE_MASK = 8'hB0;
  localparam int PORT_WAKE_BIT = 4;

  // ---
  // Enable bit positions
  // ---
  localparam int HWE_TMR1 = 1;
  localparam int HWE_INT = 2;
  localparam int HWE_PRED = 3;
  localparam int HWE_KEY = 5;
  localparam int SWE_PORTC = 4;
  localparam int SWE_INT = 5;
  localparam int SWE_KEY = 7;

  // ---
  // Synchroniser vector layout
  // ---
  localparam int SY_PORTC_LO = 0;
  localparam int SY_INT = 4;
  localparam int SY_KEY_LO = 5;
  localparam int SY_FAST_RDY = 9;

  // ---
  // Decimal adjust constants
  // ---
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [3:0] DA_ADD_ADJ = 4'h6;
  localparam logic [3:0] DA_SUB_ADJ = 4'hA;
  localparam logic [3:0] DAA_CARRY_LIM = 4'h3;
  localparam logic [3:0] DAS_LOW_LIM = 4'h6;

  // ---
  // Instruction codes
  // ---
  typedef enum logic [4:0] {
    OP_STORE_RESULT = 5'h00,
    OP_IMMEDIATE_LOAD = 5'h01,
    OP_LOAD_FROM_MEMORY = 5'h02,
    OP_TBL_HI = 5'h03,
    OP_TBL_LO = 5'h04,
    OP_TBL_HI_INC = 5'h05,
    OP_TBL_LO_INC = 5'h06,
    OP_HALT = 5'h07,
    OP_STOP = 5'h08,
    OP_HALT_PORT_WAKE_SELECT = 5'h09,
    OP_IRQ_ENABLE_SET = 5'h0A,
    OP_HALT_WAKE_ENABLE_SET = 5'h0B,
    OP_STOP_WAKE_ENABLE_SET = 5'h0C,
    OP_FAST = 5'h0D,
    OP_SLOW = 5'h0E,
    OP_BACKUP_WAKE_READ = 5'h0F,
    OP_WAKE_CAUSE_READ = 5'h10,
    OP_KEY_WAKE_READ = 5'h11,
    OP_MISC_STATUS_READ = 5'h12,
    OP_INDEX_HIGH_LOAD = 5'h13,
    OP_INDEX_LOW_LOAD = 5'h14,
    OP_DECIMAL_ADJUST_ADD = 5'h15,
    OP_DECIMAL_ADJUST_SUBTRACT = 5'h16
  } nlc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_EXEC = 3'b010,
    ST_WRITE = 3'b011,
    ST_HALT = 3'b100,
    ST_STOP = 3'b101,
    ST_FAST_WAIT = 3'b110,
    ST_SLOW_OFF = 3'b111
  } nlc_state_t;

endpackage : nlc_pkg

// *** core/nlc_dec_adjust.sv ***
// Decimal adjust of a nibble after add or subtract.
// Combinational; the caller registers the result.
module nlc_dec_adjust
  import nlc_pkg::*;
(
  // Operand
  input wire logic [3:0] value_i,
  input wire logic carry_i,
  input wire logic subtract_i,
  // Result
  output logic [3:0] value_o,
  output logic carry_o
);

  always_comb begin
    value_o = value_i;
    carry_o = carry_i;
    if (!subtract_i) begin
      if (value_i > DEC_MAX && !carry_i) begin
        value_o = value_i + DA_ADD_ADJ;
        carry_o = 1'b1;
      end else if (carry_i && value_i <= DAA_CARRY_LIM) begin
        value_o = value_i + DA_ADD_ADJ;
      end
    end else if (!carry_i && value_i >= DAS_LOW_LIM) begin
      value_o = value_i + DA_SUB_ADJ;
    end
  end

endmodule : nlc_dec_adjust

// *** core/nlc_core.sv ***
// Load/store, table read, halt/stop, wake mask, clock switch and decimal adjust unit.
// Assumes RAM and ROM reads return one cycle later.
//
// What this block does
// - Store writes nibble to memory at Rx or index; nibble kept.
// - Immediate load puts a 4-bit constant into result nibble and memory.
// - Load copies addressed memory nibble into result nibble; memory unchanged.
// - Table loads put upper or lower ROM nibble at index into memory and nibble.
// - Post-increment table loads add one to the index pointer afterwards.
// - Halt waits for interrupt, selected port C change or enabled wake.
// - Halt ended by interrupt resumes after halt once the service returns.
// - Stop halts oscillators; key level, pin change or port C high release.
// - Port wake select bit 4 lets port C changes release halt.
// - Interrupt enable set: bits 0,1,2,3,5 from operand; 4,6,7 reserved.
// - Halt wake enable set: bits 1,2,3,5 from operand; others reserved.
// - Stop wake enable set: bits 4,5,7 from operand; others reserved.
// - Fast starts the fast oscillator, then switches system clock to it.
// - Slow switches system clock to crystal, then stops the fast oscillator.
// - Backup wake read returns backup flag, port C wake, other wake flags.
// - Wake cause read returns pin, timer, predivider stage 15, overflow flags.
// - Key wake read returns the key wake flag in bit 0.
// - Misc status read returns clock select flag and watchdog enable flag.
// - Index high load takes nibble and memory; index low load takes memory.
// - Adjust add: A-F, no carry: add 6, set carry; 0-3 with carry: add 6.
// - Adjust subtract: 6-F, no carry: add ten; carry kept.
module nlc_core
  import nlc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Instruction request
  input wire logic instr_valid_i,
  input wire nlc_pkg::nlc_op_t instr_op_i,
  input wire logic [7:0] instr_operand_i,
  input wire logic [nlc_pkg::RAM_AW-1:0] instr_rx_i,
  input wire logic instr_at_index_i,
  input wire logic instr_mem_write_i,
  output logic instr_ready_o,
  output logic instr_done_o,
  // Nibble and carry shared with the ALU
  input wire logic alu_acc_we_i,
  input wire logic [3:0] alu_acc_i,
  input wire logic alu_carry_we_i,
  input wire logic alu_carry_i,
  output logic [3:0] result_nibble_reg_o,
  output logic carry_bit_o,
  output logic [nlc_pkg::IDX_W-1:0] table_index_pointer_o,
  // Data memory
  output logic [nlc_pkg::RAM_AW-1:0] mem_addr_o,
  output logic [3:0] mem_wdata_o,
  output logic mem_we_o,
  input wire logic [3:0] mem_rdata_i,
  // Table ROM
  output logic [nlc_pkg::IDX_W-1:0] rom_addr_o,
  input wire logic [nlc_pkg::ROM_DW-1:0] rom_data_i,
  // Wake pins
  input wire logic [3:0] port_c_pins_i,
  input wire logic ext_int_pin_i,
  input wire logic [3:0] key_inputs_i,
  input wire logic key_active_high_i,
  // On-chip wake sources and status
  input wire logic key_scan_window_i,
  input wire logic timer1_underflow_i,
  input wire logic predivider_overflow_i,
  input wire logic predivider_stage15_i,
  input wire logic irq_accept_i,
  input wire logic return_done_i,
  input wire logic backup_mode_flag_i,
  input wire logic watchdog_on_flag_i,
  // Enable masks
  output logic [7:0] irq_enable_bits_o,
  output logic [7:0] halt_wake_enable_bits_o,
  output logic [7:0] stop_wake_enable_bits_o,
  output logic port_c_halt_wake_o,
  // Power and clock control
  output logic halted_o,
  output logic stopped_o,
  output logic return_after_halt_o,
  output logic fast_oscillator_en_o,
  input wire logic fast_oscillator_ready_i,
  output logic sysclk_select_flag_o,
  output logic all_osc_stop_o
);
  import nlc_pkg::*;

  // ---
  // State
  // ---
  typedef struct packed {
    nlc_state_t st;
    nlc_op_t op;
    logic [7:0] operand;
    logic at_index;
    logic mem_write;
    logic [RAM_AW-1:0] rx;
    logic [3:0] acc;
    logic carry;
    logic [IDX_W-1:0] idx;
    logic [7:0] irq_en;
    logic [7:0] hwe;
    logic [7:0] swe;
    logic portc_wake;
    logic sysclk_sel;
    logic fast_en;
    logic osc_stop;
    logic wf_portc;
    logic wf_other;
    logic wf_int;
    logic wf_tmr1;
    logic wf_pred;
    logic wf_key;
    logic ret_pending;
    logic [RAM_AW-1:0] mem_addr;
    logic [3:0] mem_wdata;
    logic mem_we;
    logic [IDX_W-1:0] rom_addr;
    logic done;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [4:0] prev;
  } nlc_regs_t;

  localparam nlc_regs_t REGS_RST = '{
    st: ST_IDLE, op: OP_STORE_RESULT, operand: 8'h00, at_index: 1'b0, mem_write: 1'b0,
    rx: '0, acc: ACC_RST, carry: 1'b0, idx: IDX_RST, irq_en: EN_RST, hwe: EN_RST,
    swe: EN_RST, portc_wake: 1'b0, sysclk_sel: 1'b0, fast_en: 1'b0, osc_stop: 1'b0,
    wf_portc: 1'b0, wf_other: 1'b0, wf_int: 1'b0, wf_tmr1: 1'b0, wf_pred: 1'b0,
    wf_key: 1'b0, ret_pending: 1'b0, mem_addr: '0, mem_wdata: 4'h0, mem_we: 1'b0,
    rom_addr: IDX_RST, done: 1'b0, sync1: '0, sync2: '0, prev: 5'h00
  };

  nlc_regs_t s;
  nlc_regs_t next_s;

  // ---
  // Decimal adjust
  // ---
  logic [3:0] da_value;
  logic da_carry;

  nlc_dec_adjust u_dec_adjust (
    .value_i(s.acc),
    .carry_i(s.carry),
    .subtract_i(s.op == OP_DECIMAL_ADJUST_SUBTRACT),
    .value_o(da_value),
    .carry_o(da_carry)
  );

  // ---
  // Helpers
  // ---
  function automatic logic needs_memory(input nlc_op_t op);
    unique case (op)
      OP_HALT, OP_STOP, OP_HALT_PORT_WAKE_SELECT, OP_IRQ_ENABLE_SET,
      OP_HALT_WAKE_ENABLE_SET, OP_STOP_WAKE_ENABLE_SET, OP_FAST, OP_SLOW: needs_memory = 1'b0;
      default: needs_memory = 1'b1;
    endcase
  endfunction : needs_memory

  // Table loads write Rx; the index picks the ROM byte
  function automatic logic uses_index_addr(input nlc_op_t op, input logic at_index);
    unique case (op)
      OP_TBL_HI, OP_TBL_LO, OP_TBL_HI_INC, OP_TBL_LO_INC: uses_index_addr = 1'b0;
      default: uses_index_addr = at_index;
    endcase
  endfunction : uses_index_addr

  // ---
  // Wake detection, on synchronised pins only
  // ---
  logic [3:0] portc_now;
  logic [3:0] keys_now;
  logic int_now;
  logic portc_change;
  logic int_change;
  logic key_hit;
  logic halt_by_portc;
  logic halt_by_tmr1;
  logic halt_by_int;
  logic halt_by_pred;
  logic halt_by_key;
  logic halt_by_other;
  logic stop_release;

  assign portc_now = s.sync2[SY_PORTC_LO +: 4];
  assign keys_now = s.sync2[SY_KEY_LO +: 4];
  assign int_now = s.sync2[SY_INT];
  assign portc_change = portc_now != s.prev[3:0];
  assign int_change = int_now != s.prev[4];
  // Key polarity: LED high, LCD low
  assign key_hit = key_scan_window_i && (key_active_high_i ? |keys_now : ~&keys_now);

  assign halt_by_portc = s.portc_wake && portc_change;
  assign halt_by_tmr1 = s.hwe[HWE_TMR1] && timer1_underflow_i;
  assign halt_by_int = s.hwe[HWE_INT] && int_change;
  assign halt_by_pred = s.hwe[HWE_PRED] && predivider_overflow_i;
  assign halt_by_key = s.hwe[HWE_KEY] && key_hit;
  assign halt_by_other = halt_by_tmr1 || halt_by_int || halt_by_pred || halt_by_key;

  // Port C high at stop entry ends stop at once
  assign stop_release = (s.swe[SWE_PORTC] && |portc_now)
                     || (s.swe[SWE_INT] && int_change)
                     || (s.swe[SWE_KEY] && key_hit);

  // ---
  // Next state
  // ---
  always_comb begin
    logic [3:0] rd_value;
    logic rd_write;
    rd_value = 4'h0;
    rd_write = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.mem_we = 1'b0;
    next_s.sync1 = {fast_oscillator_ready_i, key_inputs_i, ext_int_pin_i, port_c_pins_i};
    next_s.sync2 = s.sync1;
    next_s.prev = {int_now, portc_now};
    if (return_done_i) begin
      next_s.ret_pending = 1'b0;
    end

    unique case (s.st)
      ST_IDLE: begin
        if (alu_acc_we_i) begin
          next_s.acc = alu_acc_i;
        end
        if (alu_carry_we_i) begin
          next_s.carry = alu_carry_i;
        end
        if (instr_valid_i) begin
          next_s.op = instr_op_i;
          next_s.operand = instr_operand_i;
          next_s.at_index = instr_at_index_i;
          next_s.mem_write = instr_mem_write_i;
          next_s.rx = instr_rx_i;
          next_s.mem_addr = uses_index_addr(instr_op_i, instr_at_index_i)
                            ? s.idx[RAM_AW-1:0] : instr_rx_i;
          next_s.rom_addr = s.idx;
          if (needs_memory(instr_op_i)) begin
            next_s.st = ST_ADDR;
          end else begin
            next_s.done = 1'b1;
            unique case (instr_op_i)
              OP_HALT: begin
                next_s.done = 1'b0;
                next_s.st = ST_HALT;
                next_s.wf_portc = 1'b0;
                next_s.wf_other = 1'b0;
                next_s.wf_int = 1'b0;
                next_s.wf_tmr1 = 1'b0;
                next_s.wf_pred = 1'b0;
                next_s.wf_key = 1'b0;
              end
              OP_STOP: begin
                next_s.done = 1'b0;
                next_s.st = ST_STOP;
                next_s.osc_stop = 1'b1;
              end
              OP_HALT_PORT_WAKE_SELECT: begin
                next_s.portc_wake = instr_operand_i[PORT_WAKE_BIT];
              end
              OP_IRQ_ENABLE_SET: begin
                next_s.irq_en = instr_operand_i & IRQ_EN_MASK;
              end
              OP_HALT_WAKE_ENABLE_SET: begin
                next_s.hwe = instr_operand_i & HALT_WAKE_MASK;
              end
              OP_STOP_WAKE_ENABLE_SET: begin
                next_s.swe = instr_operand_i & STOP_WAKE_MASK;
              end
              OP_FAST: begin
                next_s.done = 1'b0;
                next_s.fast_en = 1'b1;
                next_s.st = ST_FAST_WAIT;
              end
              OP_SLOW: begin
                next_s.done = 1'b0;
                next_s.sysclk_sel = 1'b0;
                next_s.st = ST_SLOW_OFF;
              end
              default: begin
              end
            endcase
          end
        end
      end

      // RAM and ROM capture the address here
      ST_ADDR: begin
        next_s.st = ST_EXEC;
      end

      ST_EXEC: begin
        next_s.st = ST_WRITE;
        unique case (s.op)
          OP_STORE_RESULT: begin
            rd_value = s.acc;
            rd_write = 1'b1;
          end
          OP_IMMEDIATE_LOAD: begin
            rd_value = s.operand[3:0];
            rd_write = 1'b1;
            next_s.acc = s.operand[3:0];
          end
          OP_LOAD_FROM_MEMORY: begin
            next_s.acc = mem_rdata_i;
          end
          OP_TBL_HI, OP_TBL_HI_INC: begin
            rd_value = rom_data_i[7:4];
            rd_write = 1'b1;
            next_s.acc = rom_data_i[7:4];
          end
          OP_TBL_LO, OP_TBL_LO_INC: begin
            rd_value = rom_data_i[3:0];
            rd_write = 1'b1;
            next_s.acc = rom_data_i[3:0];
          end
          OP_BACKUP_WAKE_READ: begin
            rd_value = {1'b0, s.wf_other, s.wf_portc, backup_mode_flag_i};
            rd_write = 1'b1;
            next_s.acc = rd_value;
          end
          OP_WAKE_CAUSE_READ: begin
            rd_value = {s.wf_pred, predivider_stage15_i, s.wf_tmr1, s.wf_int};
            rd_write = 1'b1;
            next_s.acc = rd_value;
          end
          OP_KEY_WAKE_READ: begin
            rd_value = {3'b000, s.wf_key};
            rd_write = 1'b1;
            next_s.acc = rd_value;
          end
          OP_MISC_STATUS_READ: begin
            rd_value = {2'b00, watchdog_on_flag_i, s.sysclk_sel};
            rd_write = 1'b1;
            next_s.acc = rd_value;
          end
          OP_INDEX_HIGH_LOAD: begin
            next_s.idx[IDX_W-1:4] = {s.acc, mem_rdata_i};
          end
          OP_INDEX_LOW_LOAD: begin
            next_s.idx[3:0] = mem_rdata_i;
          end
          OP_DECIMAL_ADJUST_ADD, OP_DECIMAL_ADJUST_SUBTRACT: begin
            rd_value = da_value;
            rd_write = s.mem_write;
            next_s.acc = da_value;
            next_s.carry = da_carry;
          end
          default: begin
          end
        endcase
        if (s.op == OP_TBL_HI_INC || s.op == OP_TBL_LO_INC) begin
          next_s.idx = s.idx + 12'h001;
        end
        next_s.mem_wdata = rd_value;
        next_s.mem_we = rd_write;
      end

      // Strobe stands one cycle
      ST_WRITE: begin
        next_s.st = ST_IDLE;
        next_s.done = 1'b1;
      end

      ST_HALT: begin
        if (irq_accept_i || halt_by_portc || halt_by_other) begin
          next_s.st = ST_IDLE;
          next_s.done = 1'b1;
          next_s.wf_portc = halt_by_portc;
          next_s.wf_other = halt_by_other;
          next_s.wf_int = halt_by_int;
          next_s.wf_tmr1 = halt_by_tmr1;
          next_s.wf_pred = halt_by_pred;
          next_s.wf_key = halt_by_key;
          // Set wins over a same-cycle return
          if (irq_accept_i) begin
            next_s.ret_pending = 1'b1;
          end
        end
      end

      ST_STOP: begin
        if (stop_release) begin
          next_s.osc_stop = 1'b0;
          next_s.st = ST_IDLE;
          next_s.done = 1'b1;
        end
      end

      // Switch only once the fast oscillator is stable
      ST_FAST_WAIT: begin
        if (s.sync2[SY_FAST_RDY]) begin
          next_s.sysclk_sel = 1'b1;
          next_s.st = ST_IDLE;
          next_s.done = 1'b1;
        end
      end

      ST_SLOW_OFF: begin
        next_s.fast_en = 1'b0;
        next_s.st = ST_IDLE;
        next_s.done = 1'b1;
      end
    endcase
  end

  // ---
  // Registers
  // ---
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= REGS_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---
  // Outputs
  // ---
  assign instr_ready_o = s.st == ST_IDLE;
  assign instr_done_o = s.done;
  assign result_nibble_reg_o = s.acc;
  assign carry_bit_o = s.carry;
  assign table_index_pointer_o = s.idx;
  assign mem_addr_o = s.mem_addr;
  assign mem_wdata_o = s.mem_wdata;
  assign mem_we_o = s.mem_we;
  assign rom_addr_o = s.rom_addr;
  assign irq_enable_bits_o = s.irq_en;
  assign halt_wake_enable_bits_o = s.hwe;
  assign stop_wake_enable_bits_o = s.swe;
  assign port_c_halt_wake_o = s.portc_wake;
  assign halted_o = s.st == ST_HALT;
  assign stopped_o = s.st == ST_STOP;
  assign return_after_halt_o = s.ret_pending;
  assign fast_oscillator_en_o = s.fast_en;
  assign sysclk_select_flag_o = s.sysclk_sel;
  assign all_osc_stop_o = s.osc_stop;

endmodule : nlc_core

// *** tb/nlc_mem_model.sv ***
// Data memory and table ROM on the far side of nlc_core.
// Assumes one clock; both reads return one cycle after the address.
module nlc_mem_model
  import nlc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Data memory
  input wire logic [nlc_pkg::RAM_AW-1:0] mem_addr_i,
  input wire logic [3:0] mem_wdata_i,
  input wire logic mem_we_i,
  output logic [3:0] mem_rdata_o,
  // Table ROM
  input wire logic [nlc_pkg::IDX_W-1:0] rom_addr_i,
  output logic [nlc_pkg::ROM_DW-1:0] rom_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ram [2**RAM_AW];
  // Old word on same-cycle write
  always @(posedge clk_i) begin
    if (mem_we_i) ram[mem_addr_i] <= mem_wdata_i;
    mem_rdata_o <= ram[mem_addr_i];
    rom_data_o <= rom_addr_i[7:0] ^ 8'h5A;
  end
endmodule : nlc_mem_model

// *** tb/nlc_core_assertions.sv ***
// Port-level checker for nlc_core.
// Assumes a bind to nlc_core; sees only its ports.
module nlc_core_assertions
  import nlc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Observed ports
  input wire logic instr_valid_i,
  input wire nlc_pkg::nlc_op_t instr_op_i,
  input wire logic [7:0] instr_operand_i,
  input wire logic [nlc_pkg::RAM_AW-1:0] instr_rx_i,
  input wire logic instr_at_index_i,
  input wire logic instr_ready_o,
  input wire logic instr_done_o,
  input wire logic [3:0] result_nibble_reg_o,
  input wire logic carry_bit_o,
  input wire logic [nlc_pkg::RAM_AW-1:0] mem_addr_o,
  input wire logic [3:0] mem_wdata_o,
  input wire logic mem_we_o,
  input wire logic irq_accept_i,
  input wire logic return_done_i,
  input wire logic [7:0] irq_enable_bits_o,
  input wire logic [7:0] stop_wake_enable_bits_o,
  input wire logic halted_o,
  input wire logic stopped_o,
  input wire logic return_after_halt_o,
  input wire logic fast_oscillator_en_o,
  input wire logic sysclk_select_flag_o,
  input wire logic all_osc_stop_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_take(nlc_op_t op);
    instr_valid_i && instr_ready_o && instr_op_i == op;
  endsequence
  sequence s_mem_walk;
    !instr_ready_o [*3] ##1 instr_done_o;
  endsequence
  a_load_walk: assert property (s_take(OP_LOAD_FROM_MEMORY) ##0 !instr_at_index_i |=>
    (mem_addr_o == $past(instr_rx_i)) ##0 s_mem_walk) else $error("load walk wrong");
  a_store_acc_kept: assert property (s_take(OP_STORE_RESULT) |-> ##3
    (mem_we_o && mem_wdata_o == $past(result_nibble_reg_o, 3)) ##1
    (result_nibble_reg_o == $past(result_nibble_reg_o, 4))) else $error("store wrong");
  a_irq_mask: assert property (s_take(OP_IRQ_ENABLE_SET) |=> instr_done_o ##1
    irq_enable_bits_o == ($past(instr_operand_i, 2) & IRQ_EN_MASK)) else $error("irq mask wrong");
  a_stop_mask: assert property (s_take(OP_STOP_WAKE_ENABLE_SET) |=> instr_done_o ##1
    stop_wake_enable_bits_o == ($past(instr_operand_i, 2) & STOP_WAKE_MASK)) else $error("stop mask wrong");
  a_halt_release: assert property ($fell(halted_o) |-> instr_done_o) else $error("halt end without done");
  a_fast_order: assert property ($rose(sysclk_select_flag_o) |->
    fast_oscillator_en_o && $past(fast_oscillator_en_o)) else $error("clock switched before start");
  a_slow_order: assert property ($fell(fast_oscillator_en_o) |->
    !sysclk_select_flag_o && !$past(sysclk_select_flag_o)) else $error("oscillator stopped early");
  a_return_clear: assert property (return_done_i && !irq_accept_i && !halted_o |=>
    !return_after_halt_o) else $error("return flag kept");
  a_stop_osc: assert property (stopped_o |-> all_osc_stop_o) else $error("oscillators run in stop");
  a_daa_carry: assert property (s_take(OP_DECIMAL_ADJUST_ADD) ##0
    (result_nibble_reg_o > DEC_MAX && !carry_bit_o) |-> ##[1:4] (instr_done_o && carry_bit_o))
    else $error("adjust carry missing");
endmodule : nlc_core_assertions

// *** tb/nlc_core_bench.sv ***
// Self-checking bench for nlc_core.
// Assumes the package compiles first.
module nlc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import nlc_pkg::*;
  logic clk_i = 1'b0, nrst_i = 1'b0, instr_valid_i = 1'b0, instr_at_index_i = 1'b0;
  logic instr_mem_write_i = 1'b0, alu_acc_we_i = 1'b0, alu_carry_we_i = 1'b0, alu_carry_i = 1'b0;
  logic ext_int_pin_i = 1'b0, key_active_high_i = 1'b1, key_scan_window_i = 1'b0, timer1_underflow_i = 1'b0;
  logic predivider_overflow_i = 1'b0, predivider_stage15_i = 1'b0, irq_accept_i = 1'b0, return_done_i = 1'b0;
  logic backup_mode_flag_i = 1'b1, watchdog_on_flag_i = 1'b1, fast_oscillator_ready_i = 1'b0;
  logic [3:0] alu_acc_i = 4'h0, port_c_pins_i = 4'h0, key_inputs_i = 4'h0, mem_rdata_i, result_nibble_reg_o, mem_wdata_o;
  logic [7:0] instr_operand_i = 8'h00, rom_data_i, irq_enable_bits_o, halt_wake_enable_bits_o, stop_wake_enable_bits_o;
  logic [RAM_AW-1:0] instr_rx_i = 7'h00, mem_addr_o;
  logic [IDX_W-1:0] table_index_pointer_o, rom_addr_o;
  logic instr_ready_o, instr_done_o, carry_bit_o, mem_we_o, port_c_halt_wake_o, halted_o, stopped_o;
  logic return_after_halt_o, fast_oscillator_en_o, sysclk_select_flag_o, all_osc_stop_o;
  nlc_op_t instr_op_i = OP_STORE_RESULT;
  nlc_op_t tops [4] = '{OP_TBL_HI_INC, OP_TBL_LO_INC, OP_TBL_HI, OP_TBL_LO};
  // {sub, carry in}, value, carry out, value out
  logic [15:0] da_tab [7] = '{16'h0707, 16'h0C12, 16'h1218, 16'h0909, 16'h2802, 16'h3515, 16'h2600};
  int errors = 0, checked = 0;
  always #2 clk_i = ~clk_i;
  nlc_core u_nlc_core (.*);
  nlc_mem_model u_nlc_mem_model (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_we_i(mem_we_o), .mem_rdata_o(mem_rdata_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));
  // ---
  // Access tasks
  // ---
  task automatic test_done;
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Ready is high at issue; next edge takes it
  task automatic issue(input nlc_op_t op, input logic [7:0] opd = 8'h00, input logic [6:0] rx = 7'h08,
                       input logic ai = 1'b0, input logic mw = 1'b0);
    instr_op_i = op;
    instr_operand_i = opd;
    instr_rx_i = rx;
    instr_at_index_i = ai;
    instr_mem_write_i = mw;
    instr_valid_i = 1'b1;
    tick();
    instr_valid_i = 1'b0;
  endtask : issue
  task automatic wdone;
    int i;
    i = 0;
    while (instr_done_o !== 1'b1) begin
      i++;
      if (i > 300) begin
        errors++;
        test_done();
      end
      tick();
    end
  endtask : wdone
  task automatic exec(input nlc_op_t op, input logic [7:0] opd = 8'h00, input logic [6:0] rx = 7'h08,
                      input logic ai = 1'b0, input logic mw = 1'b0);
    issue(op, opd, rx, ai, mw);
    wdone();
  endtask : exec
  task automatic setacc(input logic [3:0] a, input logic c);
    alu_acc_i = a;
    alu_carry_i = c;
    alu_acc_we_i = 1'b1;
    alu_carry_we_i = 1'b1;
    tick();
    alu_acc_we_i = 1'b0;
    alu_carry_we_i = 1'b0;
  endtask : setacc
  // ---
  // Scenarios
  // ---
  initial begin : main
    logic [11:0] p;
    logic [7:0] r;
    repeat (12) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    tick();
    exec(OP_IMMEDIATE_LOAD, 8'h0A, 7'h05);
    chk(result_nibble_reg_o, 4'hA);
    setacc(4'h0, 1'b0);
    exec(OP_LOAD_FROM_MEMORY, 8'h00, 7'h05);
    chk(result_nibble_reg_o, 4'hA);
    setacc(4'h3, 1'b0);
    exec(OP_STORE_RESULT, 8'h00, 7'h06);
    chk(result_nibble_reg_o, 4'h3);
    exec(OP_IMMEDIATE_LOAD, 8'h07, 7'h01);
    exec(OP_LOAD_FROM_MEMORY, 8'h00, 7'h06);
    chk(result_nibble_reg_o, 4'h3);
    exec(OP_INDEX_LOW_LOAD, 8'h00, 7'h01);
    chk(table_index_pointer_o[3:0], 4'h7);
    setacc(4'h1, 1'b0);
    exec(OP_INDEX_HIGH_LOAD, 8'h00, 7'h01);
    chk(table_index_pointer_o, 12'h177);
    for (int k = 0; k < 4; k++) begin
      p = table_index_pointer_o;
      r = p[7:0] ^ 8'h5A;
      exec(tops[k], 8'h00, 7'h02);
      chk(result_nibble_reg_o, k[0] ? r[3:0] : r[7:4]);
      chk(table_index_pointer_o, p + 12'(k < 2));
    end
    setacc(4'hE, 1'b0);
    exec(OP_STORE_RESULT, 8'h00, 7'h00, 1'b1);
    exec(OP_LOAD_FROM_MEMORY, 8'h00, 7'h79);
    chk(result_nibble_reg_o, 4'hE);
    exec(OP_IRQ_ENABLE_SET, 8'hFF);
    chk(irq_enable_bits_o, 8'h2F);
    exec(OP_HALT_WAKE_ENABLE_SET, 8'hFF);
    chk(halt_wake_enable_bits_o, 8'h2E);
    exec(OP_STOP_WAKE_ENABLE_SET, 8'hFF);
    chk(stop_wake_enable_bits_o, 8'hB0);
    exec(OP_HALT_PORT_WAKE_SELECT, 8'hFF);
    chk(port_c_halt_wake_o, 1'b1);
    exec(OP_HALT_PORT_WAKE_SELECT, 8'hEF);
    chk(port_c_halt_wake_o, 1'b0);
    for (int k = 0; k < 7; k++) begin
      setacc(da_tab[k][11:8], da_tab[k][12]);
      exec(da_tab[k][13] ? OP_DECIMAL_ADJUST_SUBTRACT : OP_DECIMAL_ADJUST_ADD, 8'h00, 7'h09, 1'b0, 1'b1);
      chk({carry_bit_o, result_nibble_reg_o}, {da_tab[k][4], da_tab[k][3:0]});
      setacc(4'h0, 1'b0);
      exec(OP_LOAD_FROM_MEMORY, 8'h00, 7'h09);
      chk(result_nibble_reg_o, da_tab[k][3:0]);
    end
    exec(OP_HALT_WAKE_ENABLE_SET, 8'h02);
    issue(OP_HALT);
    tick(2);
    chk(halted_o, 1'b1);
    timer1_underflow_i = 1'b1;
    tick();
    timer1_underflow_i = 1'b0;
    wdone();
    chk(return_after_halt_o, 1'b0);
    predivider_stage15_i = 1'b1;
    exec(OP_WAKE_CAUSE_READ);
    chk(result_nibble_reg_o, 4'h6);
    issue(OP_HALT);
    tick(2);
    irq_accept_i = 1'b1;
    tick();
    irq_accept_i = 1'b0;
    wdone();
    chk(return_after_halt_o, 1'b1);
    exec(OP_BACKUP_WAKE_READ);
    chk(result_nibble_reg_o, 4'h1);
    return_done_i = 1'b1;
    tick();
    return_done_i = 1'b0;
    tick();
    chk(return_after_halt_o, 1'b0);
    exec(OP_HALT_WAKE_ENABLE_SET, 8'h20);
    issue(OP_HALT);
    key_inputs_i = 4'h1;
    key_scan_window_i = 1'b1;
    wdone();
    key_inputs_i = 4'h0;
    key_scan_window_i = 1'b0;
    exec(OP_KEY_WAKE_READ);
    chk(result_nibble_reg_o, 4'h1);
    issue(OP_FAST);
    tick(3);
    chk({fast_oscillator_en_o, sysclk_select_flag_o}, 2'b10);
    fast_oscillator_ready_i = 1'b1;
    wdone();
    chk(sysclk_select_flag_o, 1'b1);
    exec(OP_MISC_STATUS_READ);
    chk(result_nibble_reg_o, 4'h3);
    exec(OP_SLOW);
    chk({sysclk_select_flag_o, fast_oscillator_en_o}, 2'b00);
    fast_oscillator_ready_i = 1'b0;
    exec(OP_STOP_WAKE_ENABLE_SET, 8'h10);
    port_c_pins_i = 4'h0;
    issue(OP_STOP);
    tick(3);
    chk({stopped_o, all_osc_stop_o}, 2'b11);
    port_c_pins_i = 4'h4;
    wdone();
    chk(stopped_o, 1'b0);
    test_done();
  end
endmodule : nlc_core_bench
bind nlc_core nlc_core_assertions u_nlc_core_assertions (.*);
